/* rtl/rsol_pkg.sv */
package rsol_pkg;
  localparam int unsigned rsol_addr_w = 5;
  localparam int unsigned rsol_data_w = 16;
  localparam logic [4:0] rsol_reg_basic_ctrl = 5'h00;
  localparam logic [4:0] rsol_reg_phy_ctrl = 5'h16;
  localparam int unsigned rsol_bit_isolate = 10;
  localparam int unsigned rsol_bit_duplex = 8;
  localparam int unsigned rsol_bit_autoneg = 12;
  localparam int unsigned rsol_bit_bcast_off = 9;
  localparam int unsigned rsol_bit_wake_en = 15;
  localparam logic [15:0] rsol_basic_ctrl_rst = 16'h0000;
  localparam logic [15:0] rsol_phy_ctrl_rst = 16'h0000;
  localparam logic [4:0] rsol_bcast_addr = 5'h00;

  typedef struct packed {
    logic wake_event_output_strap;
    logic isolate_strap;
    logic duplex_strap;
    logic autoneg_enable_strap;
    logic broadcast_addr_disable_strap;
    logic test_chain_strap_n;
  } rsol_strap_type;

  localparam rsol_strap_type rsol_strap_rst = 6'h00;

  typedef enum logic [1:0] {
    rsol_st_reset = 2'b00,
    rsol_st_capture = 2'b01,
    rsol_st_run = 2'b11
  } rsol_state_type;
endpackage : rsol_pkg

module rsol_capture
  import rsol_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire rsol_strap_type strap_pin_in,
  output rsol_strap_type strap_q,
  output logic capture_q,
  output logic running_q
);
  rsol_state_type state_q;
  rsol_state_type state_d;

  // first edge with reset released is the capture edge
  always_comb begin
    case (state_q)
      rsol_st_reset: state_d = rsol_st_capture;
      rsol_st_capture: state_d = rsol_st_run;
      rsol_st_run: state_d = rsol_st_run;
      default: state_d = rsol_st_reset;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      state_q <= rsol_st_reset;
      strap_q <= rsol_strap_rst;
      capture_q <= 1'b0;
      running_q <= 1'b0;
    end else begin
      state_q <= state_d;
      capture_q <= (state_q == rsol_st_reset);
      running_q <= (state_q != rsol_st_reset);
      if (state_q == rsol_st_reset) begin
        strap_q <= strap_pin_in;
      end
    end
  end

  chk_strap_frozen: assert property (@(posedge clock) disable iff (!reset_n)
    running_q && $past(running_q) |-> $stable(strap_q))
    else $error("strap values changed after capture");
endmodule : rsol_capture

/* rtl/rsol_top.sv */
module rsol_top
  import rsol_pkg::*;
#(
  parameter int unsigned addr_w = rsol_addr_w,
  parameter int unsigned data_w = rsol_data_w
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire rsol_strap_type strap_pin_in,
  input wire rsol_strap_type func_pin_data,
  input wire logic reg_wr_en,
  input wire logic [addr_w-1:0] reg_addr,
  input wire logic [data_w-1:0] reg_wr_data,
  input wire logic [addr_w-1:0] own_addr,
  input wire logic [addr_w-1:0] mgmt_addr,
  output rsol_strap_type pin_out_q,
  output rsol_strap_type pin_oe_q,
  output logic [data_w-1:0] basic_ctrl_q,
  output logic [data_w-1:0] phy_ctrl_q,
  output logic wake_event_output_en_q,
  output logic addr0_broadcast_q,
  output logic addr_match_q,
  output logic test_chain_en_q,
  output logic config_done_q
);
  rsol_strap_type strap_q;
  logic capture_q;
  logic running_q;
  logic [data_w-1:0] basic_ctrl_d;
  logic [data_w-1:0] phy_ctrl_d;

  rsol_capture u_capture (
    .clock(clock),
    .reset_n(reset_n),
    .strap_pin_in(strap_pin_in),
    .strap_q(strap_q),
    .capture_q(capture_q),
    .running_q(running_q)
  );

  function automatic logic hit(input logic [addr_w-1:0] a, input logic [addr_w-1:0] b);
    hit = (a == b);
  endfunction : hit

  wire wr_basic = reg_wr_en && running_q && hit(reg_addr, addr_w'(rsol_reg_basic_ctrl));
  wire wr_phy = reg_wr_en && running_q && hit(reg_addr, addr_w'(rsol_reg_phy_ctrl));
  // duplex pin low means full duplex, which is a one in bit 8
  wire full_duplex = ~strap_q.duplex_strap;
  wire bcast_off_now = phy_ctrl_q[rsol_bit_bcast_off];
  wire addr0_bcast = ~bcast_off_now;
  wire addr_hit = hit(mgmt_addr, own_addr) || (addr0_bcast && hit(mgmt_addr, addr_w'(rsol_bcast_addr)));
  wire rsol_strap_type pins_drive = running_q ? rsol_strap_type'(~rsol_strap_rst) : rsol_strap_rst;

  always_comb begin
    basic_ctrl_d = basic_ctrl_q;
    phy_ctrl_d = phy_ctrl_q;
    if (capture_q) begin
      basic_ctrl_d[rsol_bit_isolate] = strap_q.isolate_strap;
      basic_ctrl_d[rsol_bit_duplex] = full_duplex;
      basic_ctrl_d[rsol_bit_autoneg] = strap_q.autoneg_enable_strap;
      phy_ctrl_d[rsol_bit_wake_en] = strap_q.wake_event_output_strap;
      phy_ctrl_d[rsol_bit_bcast_off] = strap_q.broadcast_addr_disable_strap;
    end else begin
      if (wr_basic) begin
        basic_ctrl_d = reg_wr_data;
      end
      if (wr_phy) begin
        phy_ctrl_d = reg_wr_data;
      end
    end
  end

  // only reset or the edge after the capture edge reloads these; software owns them after
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      basic_ctrl_q <= rsol_basic_ctrl_rst;
      phy_ctrl_q <= rsol_phy_ctrl_rst;
    end else begin
      basic_ctrl_q <= basic_ctrl_d;
      phy_ctrl_q <= phy_ctrl_d;
    end
  end

  // pins stay released until the straps are safely held
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      pin_out_q <= rsol_strap_rst;
      pin_oe_q <= rsol_strap_rst;
    end else begin
      pin_out_q <= func_pin_data;
      pin_oe_q <= pins_drive;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      wake_event_output_en_q <= 1'b0;
      addr0_broadcast_q <= 1'b1;
      addr_match_q <= 1'b0;
      test_chain_en_q <= 1'b0;
      config_done_q <= 1'b0;
    end else begin
      wake_event_output_en_q <= phy_ctrl_q[rsol_bit_wake_en];
      addr0_broadcast_q <= addr0_bcast;
      addr_match_q <= addr_hit;
      test_chain_en_q <= running_q && ~strap_q.test_chain_strap_n;
      config_done_q <= running_q;
    end
  end

  chk_isolate_load: assert property (@(posedge clock) disable iff (!reset_n)
    capture_q |=> basic_ctrl_q[rsol_bit_isolate] == $past(strap_q.isolate_strap))
    else $error("isolate bit not loaded from strap");
  chk_duplex_load: assert property (@(posedge clock) disable iff (!reset_n)
    capture_q |=> basic_ctrl_q[rsol_bit_duplex] == !$past(strap_q.duplex_strap))
    else $error("duplex bit not loaded from strap");
  chk_autoneg_load: assert property (@(posedge clock) disable iff (!reset_n)
    capture_q |=> basic_ctrl_q[rsol_bit_autoneg] == $past(strap_q.autoneg_enable_strap))
    else $error("autoneg bit not loaded from strap");
  chk_wake_copy: assert property (@(posedge clock) disable iff (!reset_n)
    capture_q ##1 !wr_phy |=> wake_event_output_en_q == $past(strap_q.wake_event_output_strap, 2))
    else $error("wake enable not copied from strap");
  chk_strap_sample: assert property (@(posedge clock) disable iff (!reset_n)
    capture_q |-> strap_q == $past(strap_pin_in))
    else $error("strap not sampled at release");
  chk_bcast_mode: assert property (@(posedge clock) disable iff (!reset_n)
    capture_q ##1 !wr_phy |=> addr0_broadcast_q == !$past(strap_q.broadcast_addr_disable_strap, 2))
    else $error("address 0 broadcast mode wrong");
  chk_bcast_write: assert property (@(posedge clock) disable iff (!reset_n)
    wr_phy && !capture_q && reg_wr_data[rsol_bit_bcast_off] |=> ##1 !addr0_broadcast_q)
    else $error("bit 9 write did not make address 0 unique");
  chk_test_chain: assert property (@(posedge clock) disable iff (!reset_n)
    running_q |=> test_chain_en_q == !$past(strap_q.test_chain_strap_n))
    else $error("test chain mode does not follow strap");
  chk_pins_released: assert property (@(posedge clock) disable iff (!reset_n)
    !running_q |=> pin_oe_q == rsol_strap_rst)
    else $error("strap pins driven before capture");

  chk_pins_driven: assert property (@(posedge clock) disable iff (!reset_n)
    running_q |=> pin_oe_q == rsol_strap_type'(~rsol_strap_rst))
    else $error("pins not driven after capture");

  chk_pin_data: assert property (@(posedge clock) disable iff (!reset_n)
    running_q |=> pin_out_q == $past(func_pin_data))
    else $error("pin data does not follow output data");

  chk_basic_write: assert property (@(posedge clock) disable iff (!reset_n)
    wr_basic |=> basic_ctrl_q == $past(reg_wr_data))
    else $error("basic control write lost");

  chk_phy_write: assert property (@(posedge clock) disable iff (!reset_n)
    wr_phy |=> phy_ctrl_q == $past(reg_wr_data))
    else $error("phy control write lost");

  chk_basic_hold: assert property (@(posedge clock) disable iff (!reset_n)
    running_q && !wr_basic |=> $stable(basic_ctrl_q))
    else $error("basic control changed without a write");

  chk_phy_hold: assert property (@(posedge clock) disable iff (!reset_n)
    running_q && !wr_phy |=> $stable(phy_ctrl_q))
    else $error("phy control changed without a write");

  chk_early_write: assert property (@(posedge clock) disable iff (!reset_n)
    !running_q && !capture_q |=> $stable(basic_ctrl_q) && $stable(phy_ctrl_q))
    else $error("register changed before capture load");

  chk_bcast_load: assert property (@(posedge clock) disable iff (!reset_n)
    capture_q |=> phy_ctrl_q[rsol_bit_bcast_off] == $past(strap_q.broadcast_addr_disable_strap))
    else $error("broadcast bit not loaded from strap");

  chk_wake_load: assert property (@(posedge clock) disable iff (!reset_n)
    capture_q |=> phy_ctrl_q[rsol_bit_wake_en] == $past(strap_q.wake_event_output_strap))
    else $error("wake bit not loaded from strap");

  chk_capture_once: assert property (@(posedge clock) disable iff (!reset_n)
    capture_q |=> !capture_q)
    else $error("capture repeated");

  chk_capture_first: assert property (@(posedge clock) disable iff (!reset_n)
    capture_q |-> !running_q)
    else $error("capture while running");

  chk_done_after: assert property (@(posedge clock) disable iff (!reset_n)
    capture_q |=> ##1 config_done_q)
    else $error("config done missing after capture");

  chk_done_early: assert property (@(posedge clock) disable iff (!reset_n)
    !running_q |=> !config_done_q)
    else $error("config done before capture");

  chk_chain_early: assert property (@(posedge clock) disable iff (!reset_n)
    !running_q |=> !test_chain_en_q)
    else $error("test chain enabled before capture");

  chk_addr_own: assert property (@(posedge clock) disable iff (!reset_n)
    mgmt_addr == own_addr |=> addr_match_q)
    else $error("own address not matched");

  chk_addr0_bcast: assert property (@(posedge clock) disable iff (!reset_n)
    mgmt_addr == addr_w'(rsol_bcast_addr) && !phy_ctrl_q[rsol_bit_bcast_off] |=> addr_match_q)
    else $error("broadcast address not matched");

  chk_addr0_unique: assert property (@(posedge clock) disable iff (!reset_n)
    mgmt_addr == addr_w'(rsol_bcast_addr) && own_addr != addr_w'(rsol_bcast_addr)
      && phy_ctrl_q[rsol_bit_bcast_off] |=> !addr_match_q)
    else $error("address 0 matched while unique");

  chk_addr_other: assert property (@(posedge clock) disable iff (!reset_n)
    mgmt_addr != own_addr && mgmt_addr != addr_w'(rsol_bcast_addr) |=> !addr_match_q)
    else $error("foreign address matched");

  chk_wake_follow: assert property (@(posedge clock) disable iff (!reset_n)
    running_q |=> wake_event_output_en_q == $past(phy_ctrl_q[rsol_bit_wake_en]))
    else $error("wake enable does not follow register");

  chk_bcast_follow: assert property (@(posedge clock) disable iff (!reset_n)
    running_q |=> addr0_broadcast_q == !$past(phy_ctrl_q[rsol_bit_bcast_off]))
    else $error("broadcast mode does not follow register");
endmodule : rsol_top

/* test/rsol_board.sv */
// board pulls hold the strap level only while the device leaves the pin undriven
module rsol_board
  import rsol_pkg::*;
(
  input wire rsol_strap_type pull,
  input wire rsol_strap_type pin_out_q,
  input wire rsol_strap_type pin_oe_q,
  output rsol_strap_type strap_pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  assign strap_pin_in = (pin_oe_q & pin_out_q) | (~pin_oe_q & pull);
endmodule : rsol_board

/* test/testbench.sv */
`define chk(a, b) tests_run++; if ((a) !== (b)) begin mismatches++; $display("[FAIL] %0t mismatch", $time); end
module testbench
  import rsol_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [5:0] s; logic [15:0] b; logic [15:0] p;} rsol_row_type;
  localparam rsol_row_type rows [5] = '{'{6'h00, 16'h0100, 16'h0000}, '{6'h3f, 16'h1400, 16'h8200},
    '{6'h2a, 16'h0000, 16'h8200}, '{6'h15, 16'h1500, 16'h0000}, '{6'h0d, 16'h1000, 16'h0000}};
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic reg_wr_en = 1'b0;
  logic [4:0] reg_addr = 5'h00;
  logic [15:0] reg_wr_data = 16'h0000;
  logic [4:0] own_addr = 5'h05;
  logic [4:0] mgmt_addr = 5'h00;
  rsol_strap_type pulls = 6'h00;
  rsol_strap_type func_pin_data = 6'h00;
  rsol_strap_type strap_pin_in, pin_out_q, pin_oe_q;
  logic [15:0] basic_ctrl_q, phy_ctrl_q;
  logic wake_q, bcast_q, match_q, chain_q, done_q;
  int mismatches = 0;
  int tests_run = 0;
  always #12.5 clock = ~clock;
  rsol_board rsol_board_i (.pull(pulls), .pin_out_q(pin_out_q), .pin_oe_q(pin_oe_q), .strap_pin_in(strap_pin_in));
  rsol_top rsol_top_i (.clock(clock), .reset_n(reset_n), .strap_pin_in(strap_pin_in),
    .func_pin_data(func_pin_data), .reg_wr_en(reg_wr_en), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
    .own_addr(own_addr), .mgmt_addr(mgmt_addr), .pin_out_q(pin_out_q), .pin_oe_q(pin_oe_q),
    .basic_ctrl_q(basic_ctrl_q), .phy_ctrl_q(phy_ctrl_q), .wake_event_output_en_q(wake_q),
    .addr0_broadcast_q(bcast_q), .addr_match_q(match_q), .test_chain_en_q(chain_q), .config_done_q(done_q));
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : tally_and_finish
  // one-cycle strobe, then two edges so derived outputs settle
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_wr_en <= 1'b1;
    reg_addr <= a;
    reg_wr_data <= d;
    @(posedge clock);
    reg_wr_en <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
  endtask : wr
  initial begin
    #(2000 * 25);
    mismatches++;
    tally_and_finish();
  end
  initial begin
    for (int i = 0; i < 5; i++) begin
      @(posedge clock);
      pulls <= rows[i].s;
      reset_n <= 1'b0;
      repeat (2) @(posedge clock);
      #1;
      `chk(pin_oe_q, 6'h00)
      `chk(done_q, 1'b0)
      `chk(bcast_q, 1'b1)
      @(posedge clock);
      reset_n <= 1'b1;
      repeat (4) @(posedge clock);
      #1;
      `chk(basic_ctrl_q, rows[i].b)
      `chk(phy_ctrl_q, rows[i].p)
      `chk(wake_q, rows[i].s[5])
      `chk(bcast_q, ~rows[i].s[1])
      `chk(chain_q, ~rows[i].s[0])
      `chk(done_q, 1'b1)
      `chk(pin_oe_q, 6'h3f)
      $display("row %0d done", i);
    end
    // pins now carry output data; captured straps must not follow
    @(posedge clock);
    func_pin_data <= 6'h32;
    repeat (3) @(posedge clock);
    #1;
    `chk(pin_out_q, 6'h32)
    `chk(basic_ctrl_q, 16'h1000)
    `chk(match_q, 1'b1)
    `chk(chain_q, 1'b0)
    $display("frozen test done");
    wr(5'h16, 16'h8200);
    `chk(bcast_q, 1'b0)
    `chk(match_q, 1'b0)
    `chk(wake_q, 1'b1)
    wr(5'h01, 16'hffff);
    `chk(basic_ctrl_q, 16'h1000)
    `chk(phy_ctrl_q, 16'h8200)
    wr(5'h00, 16'h1234);
    `chk(basic_ctrl_q, 16'h1234)
    @(posedge clock);
    mgmt_addr <= 5'h05;
    repeat (2) @(posedge clock);
    #1;
    `chk(match_q, 1'b1)
    wr(5'h16, 16'h0000);
    `chk(bcast_q, 1'b1)
    `chk(wake_q, 1'b0)
    $display("write test done");
    // a write held across release is refused; the capture load wins
    @(posedge clock);
    pulls <= 6'h3f;
    reset_n <= 1'b0;
    reg_wr_en <= 1'b1;
    reg_addr <= 5'h16;
    reg_wr_data <= 16'h0000;
    repeat (3) @(posedge clock);
    reset_n <= 1'b1;
    repeat (2) @(posedge clock);
    reg_wr_en <= 1'b0;
    repeat (3) @(posedge clock);
    #1;
    `chk(phy_ctrl_q, 16'h8200)
    `chk(bcast_q, 1'b0)
    `chk(basic_ctrl_q, 16'h1400)
    $display("capture test done");
    tally_and_finish();
  end
endmodule : testbench
